//--- verilog/rsi_defines.vh
// Purpose: Constants for the receive statistics increment block.
// Assumes: APB with 32-bit data, byte addresses, one word per register.
// Notes:   Offsets, field positions, reset values and size-bin bounds.
`ifndef RSI_DEFINES_VH
`define RSI_DEFINES_VH

// ============================================================
// Register byte offsets
`define RSI_OFF_CTRL 8'h00
`define RSI_OFF_MAX_LEN 8'h04
`define RSI_OFF_INT_STATUS 8'h08
`define RSI_OFF_INT_CLEAR 8'h0c
`define RSI_OFF_INT_ENABLE 8'h10
`define RSI_OFF_FRAME_COUNT 8'h14

// ============================================================
// Control register fields
`define RSI_CTRL_CHK_PRE 0
`define RSI_CTRL_CHK_SFD 1
`define RSI_CTRL_RST 2'h0

// ============================================================
// Maximum frame length, 15 bits
`define RSI_MAX_LEN_W 15
`define RSI_MAX_LEN_RST 15'h2580

// ============================================================
// Interrupt status bit positions
`define RSI_EV_BAD_FCS 0
`define RSI_EV_STOMPED 1
`define RSI_EV_FCS_ERR_LEGAL 2
`define RSI_EV_BAD_PRE 3
`define RSI_EV_BAD_SFD 4
`define RSI_EV_SIG_OS 5
`define RSI_EV_LARGE 6
`define RSI_EV_W 7

// ============================================================
// Frame length bounds in bytes
`define RSI_LEN_W 16
`define RSI_MIN_LEGAL 16'h0040
`define RSI_BIN0_LO 16'h060d
`define RSI_BIN0_HI 16'h07ff
`define RSI_BIN1_LO 16'h0800
`define RSI_BIN1_HI 16'h0fff
`define RSI_BIN2_LO 16'h1000
`define RSI_BIN2_HI 16'h1fff
`define RSI_BIN3_LO 16'h2000
`define RSI_BIN3_HI 16'h23ff

`endif

//--- verilog/rsi_rx_stat_incr.v
// Purpose: Receive statistics increment generator with an APB register slave.
// Assumes: All inputs come from receive logic on pclk; one frame end per cycle.
// Notes:   Increment outputs are registered and appear one cycle after their input event.
`include "rsi_defines.vh"

module rsi_rx_stat_incr
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire rx_frame_end,
    input wire [`RSI_LEN_W-1:0] rx_frame_len,
    input wire [31:0] rx_fcs_calc,
    input wire [31:0] rx_fcs_recv,
    input wire rx_preamble_bad,
    input wire rx_sfd_bad,
    input wire rx_signal_os,
    output wire rx_check_preamble_en,
    output wire rx_check_sfd_en,
    output wire [`RSI_MAX_LEN_W-1:0] rx_max_frame_len,
    output reg stat_bin_1549_2047_r,
    output reg stat_bin_2048_4095_r,
    output reg stat_bin_4096_8191_r,
    output reg stat_bin_8192_9215_r,
    output reg [1:0] stat_bad_fcs_r,
    output reg [1:0] stat_stomped_fcs_r,
    output reg stat_fcs_err_legal_r,
    output reg stat_bad_preamble_r,
    output reg stat_bad_sfd_r,
    output reg rx_signal_ordered_set_seen_r,
    output wire irq
);

// ============================================================
// Helpers

// Inclusive range test on a frame length.
function in_range;
    input [`RSI_LEN_W-1:0] len;
    input [`RSI_LEN_W-1:0] lo;
    input [`RSI_LEN_W-1:0] hi;
    begin
        in_range = (len >= lo) && (len <= hi);
    end
endfunction

// Register offset match, shared by the error and clear paths.
function reg_hit;
    input [7:0] addr;
    input [7:0] off;
    begin
        reg_hit = (addr == off);
    end
endfunction

// ============================================================
// Register state

reg [1:0] ctrl_r;
reg [`RSI_MAX_LEN_W-1:0] max_len_r;
reg [`RSI_EV_W-1:0] int_status_r;
reg [`RSI_EV_W-1:0] int_status_nxt;
reg [`RSI_EV_W-1:0] int_enable_r;
reg [31:0] frame_count_r;
reg ack_r;
reg [31:0] rd_data_nxt;

wire wr_en;
wire rd_en;
wire addr_hit;
wire acc_first;

// Read data leaves a flip-flop, so every access takes one wait state: the first
// access cycle loads prdata and the second one completes the transfer.
assign acc_first = psel && penable && !ack_r;
assign pready = ack_r;
assign wr_en = psel && penable && pwrite && ack_r;
assign rd_en = psel && penable && !pwrite;

// Any offset outside this set earns an error response.
assign addr_hit = reg_hit(paddr, `RSI_OFF_CTRL) || reg_hit(paddr, `RSI_OFF_MAX_LEN)
    || reg_hit(paddr, `RSI_OFF_INT_STATUS) || reg_hit(paddr, `RSI_OFF_INT_CLEAR)
    || reg_hit(paddr, `RSI_OFF_INT_ENABLE) || reg_hit(paddr, `RSI_OFF_FRAME_COUNT);

// The checking controls only travel on to the detectors upstream.
assign rx_check_preamble_en = ctrl_r[`RSI_CTRL_CHK_PRE];
assign rx_check_sfd_en = ctrl_r[`RSI_CTRL_CHK_SFD];
assign rx_max_frame_len = max_len_r;

// ============================================================
// Frame classification

wire fcs_mismatch;
wire fcs_stomped;
wire fcs_bad;
wire len_legal;
wire [3:0] bin_hit;

assign fcs_mismatch = rx_fcs_recv != rx_fcs_calc;
assign fcs_stomped = rx_fcs_recv == ~rx_fcs_calc;
assign fcs_bad = fcs_mismatch && !fcs_stomped;

// A stomped frame still carries a check error, so it counts here too.
assign len_legal = in_range(rx_frame_len, `RSI_MIN_LEGAL,
    {{(`RSI_LEN_W-`RSI_MAX_LEN_W){1'b0}}, max_len_r});

// Bounds are packed with bin 0 in the low slice, so bin_hit[i] feeds size output i.
localparam [4*`RSI_LEN_W-1:0] BIN_LO = {`RSI_BIN3_LO, `RSI_BIN2_LO,
    `RSI_BIN1_LO, `RSI_BIN0_LO};
localparam [4*`RSI_LEN_W-1:0] BIN_HI = {`RSI_BIN3_HI, `RSI_BIN2_HI,
    `RSI_BIN1_HI, `RSI_BIN0_HI};

genvar bin_idx;
generate
    for (bin_idx = 0; bin_idx < 4; bin_idx = bin_idx + 1)
    begin : g_bin
        assign bin_hit[bin_idx] = in_range(rx_frame_len,
            BIN_LO[bin_idx*`RSI_LEN_W +: `RSI_LEN_W], BIN_HI[bin_idx*`RSI_LEN_W +: `RSI_LEN_W]);
    end
endgenerate

// ============================================================
// Increment outputs

// Every output is recomputed each cycle, so it is high in exactly the cycles that follow a cycle in which its event is present.
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        stat_bin_1549_2047_r <= 1'b0;
        stat_bin_2048_4095_r <= 1'b0;
        stat_bin_4096_8191_r <= 1'b0;
        stat_bin_8192_9215_r <= 1'b0;
        stat_bad_fcs_r <= 2'h0;
        stat_stomped_fcs_r <= 2'h0;
        stat_fcs_err_legal_r <= 1'b0;
        stat_bad_preamble_r <= 1'b0;
        stat_bad_sfd_r <= 1'b0;
        rx_signal_ordered_set_seen_r <= 1'b0;
    end
    else
    begin
        stat_bin_1549_2047_r <= rx_frame_end && bin_hit[0];
        stat_bin_2048_4095_r <= rx_frame_end && bin_hit[1];
        stat_bin_4096_8191_r <= rx_frame_end && bin_hit[2];
        stat_bin_8192_9215_r <= rx_frame_end && bin_hit[3];
        // The two-bit buses never exceed one, as at most one frame ends per cycle.
        stat_bad_fcs_r <= {1'b0, rx_frame_end && fcs_bad};
        stat_stomped_fcs_r <= {1'b0, rx_frame_end && fcs_stomped};
        stat_fcs_err_legal_r <= rx_frame_end && fcs_mismatch && len_legal;
        // Not gated by the checking controls: errors are counted even when tolerated.
        stat_bad_preamble_r <= rx_preamble_bad;
        stat_bad_sfd_r <= rx_sfd_bad;
        rx_signal_ordered_set_seen_r <= rx_signal_os;
    end
end

// ============================================================
// Interrupt status

// Status bits take the events straight from the inputs, so they are set on the
// same edge that launches the matching increment.
wire [`RSI_EV_W-1:0] ev_set;

assign ev_set[`RSI_EV_BAD_FCS] = rx_frame_end && fcs_bad;
assign ev_set[`RSI_EV_STOMPED] = rx_frame_end && fcs_stomped;
assign ev_set[`RSI_EV_FCS_ERR_LEGAL] = rx_frame_end && fcs_mismatch && len_legal;
assign ev_set[`RSI_EV_BAD_PRE] = rx_preamble_bad;
assign ev_set[`RSI_EV_BAD_SFD] = rx_sfd_bad;
assign ev_set[`RSI_EV_SIG_OS] = rx_signal_os;
assign ev_set[`RSI_EV_LARGE] = rx_frame_end && (|bin_hit);

// A new event wins over a clear written in the same cycle.
always @*
begin
    int_status_nxt = int_status_r;
    if (wr_en && reg_hit(paddr, `RSI_OFF_INT_CLEAR))
    begin
        int_status_nxt = int_status_nxt & ~pwdata[`RSI_EV_W-1:0];
    end
    int_status_nxt = int_status_nxt | ev_set;
end

// The level comes from registers only, so it cannot glitch during a bus cycle.
assign irq = |(int_status_r & int_enable_r);

// ============================================================
// Register writes

// Writes land only on the completing edge of an access, when pready is high.
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ctrl_r <= `RSI_CTRL_RST;
        max_len_r <= `RSI_MAX_LEN_RST;
        int_status_r <= {`RSI_EV_W{1'b0}};
        int_enable_r <= {`RSI_EV_W{1'b0}};
    end
    else
    begin
        int_status_r <= int_status_nxt;
        if (wr_en)
        begin
            case (paddr)
                `RSI_OFF_CTRL:
                begin
                    ctrl_r <= pwdata[1:0];
                end
                `RSI_OFF_MAX_LEN:
                begin
                    max_len_r <= pwdata[`RSI_MAX_LEN_W-1:0];
                end
                `RSI_OFF_INT_ENABLE:
                begin
                    int_enable_r <= pwdata[`RSI_EV_W-1:0];
                end
                // Status and the frame count are read-only, so a write there is dropped
                // without an error; the clear register is handled with the status.
                default:
                begin
                    ctrl_r <= ctrl_r;
                end
            endcase
        end
    end
end

// ============================================================
// Read data and error response

// Unmapped offsets answer with an error response; nothing is written there.
always @*
begin
    rd_data_nxt = 32'h0;
    pslverr = 1'b0;
    if (psel && penable && !addr_hit)
    begin
        pslverr = 1'b1;
    end
    if (rd_en)
    begin
        case (paddr)
            `RSI_OFF_CTRL:
            begin
                rd_data_nxt = {30'h0, ctrl_r};
            end
            `RSI_OFF_MAX_LEN:
            begin
                rd_data_nxt = {17'h0, max_len_r};
            end
            `RSI_OFF_INT_STATUS:
            begin
                rd_data_nxt = {25'h0, int_status_r};
            end
            `RSI_OFF_INT_ENABLE:
            begin
                rd_data_nxt = {25'h0, int_enable_r};
            end
            `RSI_OFF_FRAME_COUNT:
            begin
                rd_data_nxt = frame_count_r;
            end
            // The clear register is write-only and reads back as zero.
            `RSI_OFF_INT_CLEAR:
            begin
                rd_data_nxt = 32'h0;
            end
            default:
            begin
                rd_data_nxt = 32'h0;
            end
        endcase
    end
end

// ============================================================
// Read data register and handshake

// The word is captured in the first access cycle and cleared once the access
// completes, so a stale value never lingers on the bus between reads.
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ack_r <= 1'b0;
        prdata <= 32'h0;
    end
    else
    begin
        ack_r <= acc_first;
        if (acc_first && !pwrite)
        begin
            prdata <= rd_data_nxt;
        end
        else if (ack_r)
        begin
            prdata <= 32'h0;
        end
    end
end

// ============================================================
// Frame counter

// The count wraps silently; software must read it often enough to notice a wrap.
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        frame_count_r <= 32'h0;
    end
    else if (rx_frame_end)
    begin
        frame_count_r <= frame_count_r + 32'h1;
    end
end

endmodule // rsi_rx_stat_incr

//--- sim/rsi_stat_chk.sv
// Purpose: Assertions on the increment outputs.
// Assumes: Increments lag their events by one pclk.
// Notes: Bound after the module.
module rsi_stat_chk (
    input wire pclk,
    input wire presetn,
    input wire rx_frame_end,
    input wire [15:0] rx_frame_len,
    input wire [31:0] rx_fcs_calc,
    input wire [31:0] rx_fcs_recv,
    input wire rx_preamble_bad,
    input wire rx_sfd_bad,
    input wire rx_signal_os,
    input wire [14:0] rx_max_frame_len,
    input wire stat_bin_1549_2047_r,
    input wire stat_bin_2048_4095_r,
    input wire stat_bin_4096_8191_r,
    input wire stat_bin_8192_9215_r,
    input wire [1:0] stat_bad_fcs_r,
    input wire [1:0] stat_stomped_fcs_r,
    input wire stat_fcs_err_legal_r,
    input wire stat_bad_preamble_r,
    input wire stat_bad_sfd_r,
    input wire rx_signal_ordered_set_seen_r
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire stomp = rx_frame_end && rx_fcs_recv == ~rx_fcs_calc;
    wire err = rx_frame_end && rx_fcs_recv != rx_fcs_calc;
    wire bad = err && !stomp;
    wire legal = err && rx_frame_len >= 64 && rx_frame_len <= {1'b0, rx_max_frame_len};
    wire [2:0] flags = {rx_preamble_bad, rx_sfd_bad, rx_signal_os};
    sequence s_l(lo, hi);
        rx_frame_end && rx_frame_len >= lo && rx_frame_len <= hi;
    endsequence
    AST_B0: assert property (s_l(1549, 2047) |=> stat_bin_1549_2047_r) else $error("b");
    AST_B1: assert property (s_l(2048, 4095) |=> stat_bin_2048_4095_r) else $error("b");
    AST_B2: assert property (s_l(4096, 8191) |=> stat_bin_4096_8191_r) else $error("b");
    AST_B3: assert property (s_l(8192, 9215) |=> stat_bin_8192_9215_r) else $error("b");
    AST_QUIET: assert property (!rx_frame_end |=>
        {stat_bin_1549_2047_r, stat_bin_2048_4095_r, stat_bin_4096_8191_r, stat_bin_8192_9215_r,
        stat_bad_fcs_r, stat_stomped_fcs_r, stat_fcs_err_legal_r} == 0) else $error("q");
    AST_BAD: assert property (1 |=> stat_bad_fcs_r == {1'b0, $past(bad)})
        else $error("bad");
    AST_STOMP: assert property (1 |=> stat_stomped_fcs_r == {1'b0, $past(stomp)})
        else $error("stomp");
    AST_LEGAL: assert property (1 |=> stat_fcs_err_legal_r == $past(legal))
        else $error("legal");
    AST_FLAGS: assert property (1 |=> {stat_bad_preamble_r, stat_bad_sfd_r,
        rx_signal_ordered_set_seen_r} == $past(flags)) else $error("flags");
endmodule // rsi_stat_chk
bind rsi_rx_stat_incr rsi_stat_chk rsi_stat_chk_inst (.pclk, .presetn, .rx_frame_end,
    .rx_frame_len, .rx_fcs_calc, .rx_fcs_recv, .rx_preamble_bad, .rx_sfd_bad, .rx_signal_os,
    .rx_max_frame_len, .stat_bin_1549_2047_r, .stat_bin_2048_4095_r, .stat_bin_4096_8191_r,
    .stat_bin_8192_9215_r, .stat_bad_fcs_r, .stat_stomped_fcs_r, .stat_fcs_err_legal_r,
    .stat_bad_preamble_r, .stat_bad_sfd_r, .rx_signal_ordered_set_seen_r);

//--- sim/rsi_cnt_model.sv
// Purpose: User statistics counters fed by the increments.
// Assumes: incr packs bins, bad, stomped, legal, preamble, delimiter, signal set.
// Notes: Zero means no event, so a plain add each cycle loses nothing.
module rsi_cnt_model (
    input wire pclk,
    input wire presetn,
    input wire [11:0] incr,
    output logic [31:0] bins_total,
    output logic [31:0] errs_total
);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bins_total <= '0;
            errs_total <= '0;
        end
        else
        begin
            bins_total <= bins_total + incr[11] + incr[10] + incr[9] + incr[8];
            errs_total <= errs_total + incr[7:6] + incr[5:4] + incr[3] + incr[2] + incr[1]
                + incr[0];
        end
    end
endmodule // rsi_cnt_model

//--- sim/rx_stat_increment_outputs_test.sv
// Purpose: Self-checking bench for the statistics increment block.
// Assumes: APB slave may stretch an access; increments lag their events by one cycle.
// Notes: A reference model predicts every increment each cycle.
module rx_stat_increment_outputs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic rx_frame_end = 0, rx_preamble_bad = 0, rx_sfd_bad = 0, rx_signal_os = 0;
    logic [7:0] paddr = '0;
    logic [15:0] rx_frame_len = '0;
    logic [31:0] pwdata = '0, rx_fcs_calc = '0, rx_fcs_recv = '0, c, q, seed = 32'hf387;
    logic [31:0] prdata, bins_total, errs_total;
    logic [14:0] rx_max_frame_len;
    logic [11:0] expv = '0;
    logic [6:0] sts = '0;
    logic pready, pslverr, irq, rx_check_preamble_en, rx_check_sfd_en, stat_bin_1549_2047_r;
    logic stat_bin_2048_4095_r, stat_bin_4096_8191_r, stat_bin_8192_9215_r, stat_fcs_err_legal_r;
    logic [1:0] stat_bad_fcs_r, stat_stomped_fcs_r;
    logic stat_bad_preamble_r, stat_bad_sfd_r, rx_signal_ordered_set_seen_r;
    int num_errors = 0, checked = 0, cyc = 0, bt = 0, et = 0, fc = 0, mx = 9600, k;
    int lens[14] = '{63, 64, 1548, 1549, 2047, 2048, 4095, 4096, 8191, 8192, 9215, 9216, 9600, 9601};
    wire [11:0] got = {stat_bin_1549_2047_r, stat_bin_2048_4095_r, stat_bin_4096_8191_r,
        stat_bin_8192_9215_r, stat_bad_fcs_r, stat_stomped_fcs_r, stat_fcs_err_legal_r,
        stat_bad_preamble_r, stat_bad_sfd_r, rx_signal_ordered_set_seen_r};
    rsi_rx_stat_incr rsi_rx_stat_incr_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .rx_frame_end, .rx_frame_len, .rx_fcs_calc,
        .rx_fcs_recv, .rx_preamble_bad, .rx_sfd_bad, .rx_signal_os, .rx_check_preamble_en,
        .rx_check_sfd_en, .rx_max_frame_len, .stat_bin_1549_2047_r, .stat_bin_2048_4095_r,
        .stat_bin_4096_8191_r, .stat_bin_8192_9215_r, .stat_bad_fcs_r, .stat_stomped_fcs_r,
        .stat_fcs_err_legal_r, .stat_bad_preamble_r, .stat_bad_sfd_r,
        .rx_signal_ordered_set_seen_r, .irq);
    rsi_cnt_model rsi_cnt_model_inst (.pclk, .presetn, .incr(got), .bins_total, .errs_total);
    initial forever #50 pclk = ~pclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
        checked++;
        if (y !== x)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, x, y);
        end
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Ends one idle cycle later, so back-to-back calls never drive psel twice at one edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic step(input logic [31:0] f, l, cv, rv, x);
        logic [11:0] nx;
        nx = {f[0] && l >= 1549 && l <= 2047, f[0] && l >= 2048 && l <= 4095,
            f[0] && l >= 4096 && l <= 8191, f[0] && l >= 8192 && l <= 9215, 1'b0,
            f[0] && rv != cv && rv != ~cv, 1'b0, f[0] && rv == ~cv,
            f[0] && rv != cv && l >= 64 && l <= mx, x[2:0]};
        bt += nx[11] + nx[10] + nx[9] + nx[8];
        et += nx[6] + nx[4] + nx[3] + nx[2] + nx[1] + nx[0];
        fc += f[0];
        sts |= {|nx[11:8], nx[0], nx[1], nx[2], nx[3], nx[4], nx[6]};
        @(posedge pclk);
        rx_frame_end <= f[0];
        rx_frame_len <= l[15:0];
        rx_fcs_calc <= cv;
        rx_fcs_recv <= rv;
        {rx_preamble_bad, rx_sfd_bad, rx_signal_os} <= x[2:0];
        @(negedge pclk);
        chk("stat", expv, got);
        expv = nx;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, 8'h04, '0);
        chk("max_len", 32'h2580, q);
        apb(0, 8'h18, '0);
        chk("slverr", 1, e);
        apb(1, 8'h10, '0);
        for (int p = 0; p < 2; p++)
        begin
            apb(1, 8'h00, p + 1);
            apb(1, 8'h04, mx);
            chk("ctrl", p + 1, {rx_check_sfd_en, rx_check_preamble_en});
            chk("max_port", mx, rx_max_frame_len);
            repeat (300)
            begin
                c = rnd();
                k = rnd() % 3;
                step(rnd(), lens[rnd() % 14], c, k == 0 ? c : k == 1 ? ~c : c ^ rnd(), rnd());
            end
            step(0, 0, 0, 0, 0);
            @(posedge pclk);
            mx = 2047;
        end
        apb(0, 8'h08, '0);
        chk("status", sts, q);
        apb(0, 8'h14, '0);
        chk("frame_count", fc, q);
        chk("bins_total", bt, bins_total);
        chk("errs_total", et, errs_total);
        chk("irq_masked", 0, irq);
        apb(1, 8'h10, 32'h7f);
        chk("irq_on", 1, irq);
        apb(1, 8'h0c, 32'h7f);
        chk("irq_off", 0, irq);
        apb(0, 8'h08, '0);
        chk("cleared", 0, q);
        report_and_stop();
    end
endmodule // rx_stat_increment_outputs_test
